/* File: rtl/drsr_map.vh */
// Constants for the dual rail sequencer and reset supervisor
`ifndef DRSR_MAP_VH
`define DRSR_MAP_VH

// Register offsets (byte addresses)
`define DRSR_CTRL_OFF 12'h000
`define DRSR_STAT_OFF 12'h004
`define DRSR_CNT_OFF 12'h008

// Control register fields
`define DRSR_CTRL_ENABLE_N_BIT 0
`define DRSR_CTRL_ORDER_BIT 1
`define DRSR_CTRL_RESET 2'h1

// Status register fields
`define DRSR_STAT_RAIL_A_ON_BIT 0
`define DRSR_STAT_RAIL_B_ON_BIT 1
`define DRSR_STAT_GOOD_BIT 2
`define DRSR_STAT_RESET_BIT 3
`define DRSR_STAT_STATE_LSB 4

// Timing: reset delay in ms and clock rate
`define DRSR_RESET_DELAY_MS 120
`define DRSR_CLK_HZ 100000000
`define DRSR_RESET_DELAY_CYC ((`DRSR_CLK_HZ / 1000) * `DRSR_RESET_DELAY_MS)

`endif

/* File: rtl/drsr_sync.v */
// Two-flop synchroniser bank for external levels
module drsr_sync #(
    parameter WIDTH = 6
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* File: rtl/drsr_top.v */
// Dual rail power sequencer with reset supervisor and APB registers
//
// What this block does
// - While enable_n is high both rails stay off and output1_good and reset_out stay low.
// - With order_select and the control order bit low, rail A is switched on first once enable_n and the control enable_n bit are both low.
// - With order_select high, rail B is switched on first once enable_n and the control enable_n bit are both low.
// - The second rail starts only once the first rail reports 83% of its target.
// - output1_good goes high once rail A reports 95% of its target.
// - Reset is released only while both rails report at least 95%.
// - Both manual holds must also be high, and reset rises after a 120 ms delay.
// - When enable_n returns high both rails turn off and both outputs go low.
// - manual_hold_a low forces reset low while the rails stay in regulation.
// - When manual_hold_a returns high with all else good, reset rises after a fresh 120 ms.
// - Rail B below 95% drops reset, and with order_select high rail A powers down too.
// - Rail A below 95% drops output1_good.
//
// The APB register port and the register offsets were chosen for this implementation.
`include "drsr_map.vh"

module drsr_top #(
    parameter [31:0] RESET_DELAY_CYC = `DRSR_RESET_DELAY_CYC
) (
    input wire clk,
    input wire rst,
    input wire enable_n,
    input wire order_select,
    input wire manual_hold_a_n,
    input wire manual_hold_b_n,
    input wire rail_a_at_83,
    input wire rail_a_at_95,
    input wire rail_b_at_83,
    input wire rail_b_at_95,
    output reg rail_a_on,
    output reg rail_b_on,
    output reg output1_good,
    output reg reset_out,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);
    // Sequencer states
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_FIRST = 3'h1;
    localparam [2:0] ST_BOTH = 3'h2;
    localparam [2:0] ST_FAULT_DOWN = 3'h3;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [31:0] delay_reg;
    reg [31:0] delay_next;
    reg [1:0] ctrl_reg;
    reg rail_a_next;
    reg rail_b_next;
    reg reset_next;
    reg order_reg;
    wire [5:0] sync_q;

    // External pins pass two flops before any use
    drsr_sync #(.WIDTH(6)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({enable_n, order_select, manual_hold_a_n, manual_hold_b_n,
            rail_a_at_95, rail_b_at_95}),
        .sync_out(sync_q)
    );

    // Second sync bank for the 83% comparators
    wire [1:0] sync83_q;
    drsr_sync #(.WIDTH(2)) u_sync83 (
        .clk(clk),
        .rst(rst),
        .async_in({rail_a_at_83, rail_b_at_83}),
        .sync_out(sync83_q)
    );

    wire en_pin_n = sync_q[5];
    wire order_pin = sync_q[4];
    wire hold_a_n = sync_q[3];
    wire hold_b_n = sync_q[2];
    wire a95 = sync_q[1];
    wire b95 = sync_q[0];
    wire a83 = sync83_q[1];
    wire b83 = sync83_q[0];

    // Software may also hold the rails off; either source disables
    wire en_n_eff = en_pin_n | ctrl_reg[`DRSR_CTRL_ENABLE_N_BIT];
    // Order is pin OR software bit
    wire order_eff = order_pin | ctrl_reg[`DRSR_CTRL_ORDER_BIT];

    // Level of the rail that leads in the chosen order
    function first_at_83;
        input ord;
        input la;
        input lb;
        begin
            first_at_83 = ord ? lb : la;
        end
    endfunction

    // Reset release conditions apart from enable, which the delay logic adds
    wire release_ok = a95 & b95 & hold_a_n & hold_b_n & (state_reg == ST_BOTH);

    // Sequencer next state and rail enables
    always @* begin
        state_next = state_reg;
        rail_a_next = rail_a_on;
        rail_b_next = rail_b_on;
        if (en_n_eff) begin
            state_next = ST_OFF;
            rail_a_next = 1'b0;
            rail_b_next = 1'b0;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    // Order latched at start so a mid-ramp change cannot swap rails
                    state_next = ST_FIRST;
                    rail_a_next = ~order_eff;
                    rail_b_next = order_eff;
                end
                ST_FIRST: begin
                    if (first_at_83(order_reg, a83, b83)) begin
                        state_next = ST_BOTH;
                        rail_a_next = 1'b1;
                        rail_b_next = 1'b1;
                    end
                end
                ST_BOTH: begin
                    // Rail B fault with B-first order takes rail A down
                    if (!b95 && order_reg && reset_out) begin
                        state_next = ST_FAULT_DOWN;
                        rail_a_next = 1'b0;
                    end
                end
                ST_FAULT_DOWN: begin
                    // Stays down until enable cycles
                    rail_a_next = 1'b0;
                end
                default: begin
                    state_next = ST_OFF;
                    rail_a_next = 1'b0;
                    rail_b_next = 1'b0;
                end
            endcase
        end
    end

    // Delay counter restarts whenever a condition drops
    always @* begin
        delay_next = delay_reg;
        reset_next = reset_out;
        if (!release_ok || en_n_eff) begin
            delay_next = 32'h0000_0000;
            reset_next = 1'b0;
        end else if (delay_reg >= RESET_DELAY_CYC - 32'h0000_0001) begin
            reset_next = 1'b1;
        end else begin
            delay_next = delay_reg + 32'h0000_0001;
        end
    end

    // Sequencer and supervisor registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_OFF;
            rail_a_on <= 1'b0;
            rail_b_on <= 1'b0;
            order_reg <= 1'b0;
            delay_reg <= 32'h0000_0000;
            reset_out <= 1'b0;
            output1_good <= 1'b0;
        end else begin
            state_reg <= state_next;
            rail_a_on <= rail_a_next;
            rail_b_on <= rail_b_next;
            if (state_reg == ST_OFF) begin
                order_reg <= order_eff;
            end
            delay_reg <= delay_next;
            reset_out <= reset_next;
            // Good follows rail A threshold while enabled
            output1_good <= ~en_n_eff & a95 & (state_reg != ST_OFF);
        end
    end

    // Register read mux
    function [31:0] rd_word;
        input [11:0] addr;
        input [1:0] ctrl;
        input [7:0] stat;
        input [31:0] cnt;
        begin
            case (addr)
                `DRSR_CTRL_OFF: rd_word = {30'h0000_0000, ctrl};
                `DRSR_STAT_OFF: rd_word = {24'h00_0000, stat};
                `DRSR_CNT_OFF: rd_word = cnt;
                default: rd_word = 32'h0000_0000;
            endcase
        end
    endfunction

    wire addr_hit = (paddr == `DRSR_CTRL_OFF) | (paddr == `DRSR_STAT_OFF) |
        (paddr == `DRSR_CNT_OFF);
    wire [7:0] stat_word = {1'b0, state_reg, reset_out, output1_good, rail_b_on, rail_a_on};

    // APB slave: one wait state, answer on the second access cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `DRSR_CTRL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                pready <= 1'b1;
                pslverr <= ~addr_hit;
                prdata <= pwrite ? 32'h0000_0000 : rd_word(paddr, ctrl_reg, stat_word, delay_reg);
                if (pwrite && paddr == `DRSR_CTRL_OFF) begin
                    ctrl_reg <= pwdata[1:0];
                end
            end
        end
    end
endmodule

/* File: verif/drsr_rail_model.sv */
// Behavioural rails: level ramps while switched on, decays when off or faulted
module drsr_rail_model (
    input wire clk, rst, rail_a_on, rail_b_on, fault_a, fault_b,
    output logic rail_a_at_83, rail_a_at_95, rail_b_at_83, rail_b_at_95
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] a_reg, b_reg;
    function automatic logic [3:0] step(input logic [3:0] v, input logic up);
        return up ? ((v == 4'hA) ? v : v + 4'h1) : ((v == 4'h0) ? v : v - 4'h1);
    endfunction
    // Slow ramp, so a rail never looks good the cycle it is switched on
    always_ff @(posedge clk or posedge rst) begin
        a_reg <= rst ? 4'h0 : step(a_reg, rail_a_on && !fault_a);
        b_reg <= rst ? 4'h0 : step(b_reg, rail_b_on && !fault_b);
    end
    // Full scale is ten steps: nine passes 83%, ten passes 95%
    assign rail_a_at_83 = a_reg > 4'h8;
    assign rail_a_at_95 = a_reg == 4'hA;
    assign rail_b_at_83 = b_reg > 4'h8;
    assign rail_b_at_95 = b_reg == 4'hA;
endmodule

/* File: verif/drsr_monitor.sv */
// Checker of rail order, good flag and reset release at the top ports
module drsr_monitor #(parameter [31:0] RESET_DELAY_CYC = 20) (
    input wire clk, rst, enable_n, order_select, manual_hold_a_n, manual_hold_b_n,
    input wire rail_a_at_83, rail_a_at_95, rail_b_at_83, rail_b_at_95,
    input wire rail_a_on, rail_b_on, output1_good, reset_out, psel, penable, pready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] held_reg;
    wire ok = !enable_n && rail_a_at_95 && rail_b_at_95 && manual_hold_a_n && manual_hold_b_n;
    // Cycles the release condition has held at the pins, saturating
    always_ff @(posedge clk or posedge rst)
        held_reg <= (rst || !ok) ? 8'h00 : held_reg + {7'h0, held_reg != 8'hFF};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    disabled_off_a:
        assert property (enable_n [*6] |-> !(rail_a_on | rail_b_on | output1_good | reset_out))
        else $error("output active while disabled");
    a_then_b_a:
        assert property ($rose(rail_b_on) && rail_a_on |-> $past(rail_a_at_83, 2))
        else $error("rail b started early");
    b_then_a_a:
        assert property ($rose(rail_a_on) && rail_b_on |-> $past(rail_b_at_83, 2))
        else $error("rail a started early");
    good_rise_a:
        assert property ($rose(output1_good) |-> $past(rail_a_at_95, 2))
        else $error("good flag without rail a");
    good_drop_a:
        assert property (!rail_a_at_95 [*6] |-> !output1_good) else $error("good flag stuck");
    hold_drop_a:
        assert property (!(manual_hold_a_n && manual_hold_b_n) [*5] |-> !reset_out)
        else $error("reset released under hold");
    release_min_a:
        assert property ($rose(reset_out) |-> held_reg >= RESET_DELAY_CYC)
        else $error("reset released early");
    release_max_a:
        assert property (held_reg == RESET_DELAY_CYC + 8 |-> reset_out)
        else $error("reset release late");
    b_fault_a:
        assert property (reset_out && order_select && !rail_b_at_95 |-> ##[1:6] !rail_a_on)
        else $error("rail a kept on after rail b fault");
    apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bad ready timing");
endmodule
bind drsr_top drsr_monitor #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_mon (.*);

/* File: verif/dual_rail_sequencer_reset_test.sv */
// Self-checking bench for the dual rail sequencer
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module dual_rail_sequencer_reset_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] DELAY = 20;
    logic clk = 0, rst = 1, enable_n = 1, order_select = 0, fault_a = 0, fault_b = 0;
    logic manual_hold_a_n = 1, manual_hold_b_n = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, rail_a_on, rail_b_on, output1_good, reset_out;
    logic rail_a_at_83, rail_a_at_95, rail_b_at_83, rail_b_at_95;
    int n_mismatch = 0, n_checks = 0;
    drsr_top #(.RESET_DELAY_CYC(DELAY)) DUT (.*);
    drsr_rail_model u_rails (.*);
    initial forever #5 clk = ~clk;
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic lost();
        $display("[FAIL] %0t wait timed out", $time);
        n_mismatch++;
        results();
    endtask
    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge clk);
        if (pready !== 1'b1) lost();
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_for(ref logic s, input logic v);
        int i;
        for (i = 0; i < 300 && s !== v; i++) @(posedge clk);
        if (s !== v) lost();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(0, 12'h000, 0);
        `CHK(rd, 32'h1)
        apb(0, 12'h00C, 0);
        `CHK({er, rd}, 33'h100000000)
        apb(1, 12'h000, 0);
        idle(10);
        `CHK(rail_a_on | rail_b_on | output1_good | reset_out, 1'b0)
        $display("test registers done");
        enable_n <= 1'b0;
        wait_for(rail_a_on, 1);
        `CHK(rail_b_on, 1'b0)
        wait_for(rail_b_on, 1);
        `CHK(rail_a_at_83, 1'b1)
        wait_for(output1_good, 1);
        wait_for(reset_out, 1);
        apb(0, 12'h004, 0);
        `CHK({er, rd}, 33'h00000002F)
        manual_hold_a_n <= 1'b0;
        wait_for(reset_out, 0);
        `CHK(rail_a_on & rail_b_on, 1'b1)
        manual_hold_a_n <= 1'b1;
        idle(10);
        manual_hold_a_n <= 1'b0;
        idle(4);
        manual_hold_a_n <= 1'b1;
        idle(15);
        `CHK(reset_out, 1'b0)
        wait_for(reset_out, 1);
        manual_hold_b_n <= 1'b0;
        wait_for(reset_out, 0);
        manual_hold_b_n <= 1'b1;
        fault_a <= 1'b1;
        wait_for(output1_good, 0);
        fault_a <= 1'b0;
        enable_n <= 1'b1;
        idle(8);
        `CHK(rail_a_on | rail_b_on | output1_good | reset_out, 1'b0)
        $display("test order a done");
        idle(12);
        {order_select, enable_n} <= 2'b10;
        wait_for(rail_b_on, 1);
        `CHK(rail_a_on, 1'b0)
        wait_for(reset_out, 1);
        fault_b <= 1'b1;
        wait_for(reset_out, 0);
        wait_for(rail_a_on, 0);
        {enable_n, fault_b} <= 2'b10;
        $display("test order b done");
        results();
    end
endmodule
